// *** inc/avc_pkg.sv ***
// Shared constants for the vendor command issuer
package avc_pkg;
  // APB register byte addresses
  localparam logic [7:0] REG_CTRL    = 8'h00;
  localparam logic [7:0] REG_STATUS  = 8'h04;
  localparam logic [7:0] REG_CFG_IDX = 8'h08;
  localparam logic [7:0] REG_CFG_DAT = 8'h0c;
  localparam logic [7:0] REG_STATE   = 8'h10;
  // Control register fields
  localparam int CTRL_START_ID = 0;
  localparam int CTRL_DEV      = 1;
  // Task file register indices
  localparam logic [2:0] TF_DATA   = 3'h0;
  localparam logic [2:0] TF_FEAT   = 3'h1;
  localparam logic [2:0] TF_SECCNT = 3'h2;
  localparam logic [2:0] TF_CYL_LO = 3'h4;
  localparam logic [2:0] TF_CYL_HI = 3'h5;
  localparam logic [2:0] TF_DEVHD  = 3'h6;
  localparam logic [2:0] TF_CMD    = 3'h7;
  // Status bits
  localparam int ST_BSY  = 7;
  localparam int ST_DRDY = 6;
  localparam int ST_DRQ  = 3;
  localparam int ST_ERR  = 0;
  // Identify command and device/head low nibble
  localparam logic [7:0] CMD_IDENTIFY = 8'hfb;
  localparam logic [3:0] DEVHD_LOW    = 4'h1;
  localparam int         DEVHD_DEV    = 4;
  // Identify block geometry, in 16-bit words
  localparam logic [8:0] ID_WORDS   = 9'h100;
  localparam logic [8:0] KEEP_WORDS = 9'h080;
  // Identify word whose low byte is config byte 2, the event command code
  localparam logic [6:0] EVCODE_WORD = 7'h01;
  localparam logic [7:0] EV_OFF      = 8'h00;
  // Saved state reset value
  localparam logic [7:0] STATE_RST = 8'h00;
  // Event vector width: features byte plus two speed bits
  localparam int EV_W = 10;
  // Issuer states
  typedef enum logic [3:0] {
    AVC_IDLE, AVC_ID_DEV, AVC_ID_CMD, AVC_ID_POLL, AVC_ID_DATA, AVC_ID_END,
    AVC_EV_POLL0, AVC_EV_WR, AVC_EV_POLL1, AVC_EV_RD_LO, AVC_EV_RD_HI
  } avc_state_e;
endpackage

// *** hdl/avc_cfg_ram.sv ***
// Configuration store: keeps the first half of the identify block
`timescale 1ns/100ps
`default_nettype none
module avc_cfg_ram
  import avc_pkg::*;
#(
  parameter int WORDS = 128
) (
  input  wire logic        clk,
  input  wire logic        we,
  input  wire logic [6:0]  waddr,
  input  wire logic [15:0] wdata,
  input  wire logic [7:0]  raddr,
  output logic      [7:0]  rdata
);
  logic [15:0] mem [WORDS];  // Word store, low byte is the even byte

  // Write port, one identify word per strobe
  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  // Registered byte read for software
  always_ff @(posedge clk) begin
    rdata <= raddr[0] ? mem[raddr[7:1]][15:8] : mem[raddr[7:1]][7:0];
  end
endmodule
`default_nettype wire

// *** hdl/avc_evt_acc.sv ***
// Event accumulator with paired-event follow-up handling
`timescale 1ns/100ps
`default_nettype none
module avc_evt_acc
  import avc_pkg::*;
#(
  parameter int PAIRS = EV_W / 2
) (
  input  wire logic               clk,
  input  wire logic               rst,
  input  wire logic [2*PAIRS-1:0] ev_in,
  input  wire logic               done_ok,
  input  wire logic [2*PAIRS-1:0] snap,
  output logic      [2*PAIRS-1:0] pend
);
  logic [PAIRS-1:0] latest_hi;  // Which half of each pair came last

  genvar p;
  generate
    for (p = 0; p < PAIRS; p++) begin : g_pair
      // Track most recent event of the pair; a same-cycle pair favours high
      always_ff @(posedge clk) begin
        if (rst) begin
          latest_hi[p] <= 1'b0;
        end else if (ev_in[2*p+1]) begin
          latest_hi[p] <= 1'b1;
        end else if (ev_in[2*p]) begin
          latest_hi[p] <= 1'b0;
        end
      end
      // Clear reported bits on success; new events win over the clear
      always_ff @(posedge clk) begin
        if (rst) begin
          pend[2*p+1:2*p] <= 2'h0;
        end else begin
          pend[2*p+1:2*p] <= (pend[2*p+1:2*p] & ~(done_ok ? snap[2*p+1:2*p] : 2'h0))
                           | ((done_ok && (&snap[2*p+1:2*p]))
                              ? {latest_hi[p], ~latest_hi[p]} : 2'h0)
                           | ev_in[2*p+1:2*p];
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

// *** hdl/avc_issuer.sv ***
// Vendor command issuer: identify fetch and event notification sequencer
// How it works
// - Identify writes FBh, device/head low nibble 0001
// - Read all 512 bytes, keep first 256
// - Event code from config byte 2; zero disables
// - Event notify is non-data: writes then command
// - Features register carries eight event flags
// - Sector count carries high/full speed bits
// - Cylinder registers carry saved state bytes
// - Reset clears both saved state bytes
// - Read back next-state bytes at completion
// - Wait BSY and DRQ clear before notify writes
// - Wait BSY and DRQ clear before readback
// - Notify after drive reset and initialization
// - Notify on every reportable event
// - Merged pairs followed by latest-only command
// - Failed notify is retried with new events
// - Success ignores the ERR bit
// - DRQ during notify means keep polling
//
// The address map and the APB register port are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module avc_issuer
  import avc_pkg::*;
(
  input  wire logic         clk,
  input  wire logic         rst,
  // APB slave
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [7:0]   paddr,
  input  wire logic [31:0]  pwdata,
  output logic              pready,
  output logic      [31:0]  prdata,
  output logic              pslverr,
  // Task file access port toward the ATA pin engine
  output logic              tf_req,
  output logic              tf_wr,
  output logic      [2:0]   tf_addr,
  output logic      [15:0]  tf_wdata,
  input  wire logic         tf_ack,
  input  wire logic [15:0]  tf_rdata,
  // System events, one-cycle pulses
  input  wire logic [EV_W-1:0] ev_in,
  input  wire logic         drive_ready,
  input  wire logic         drive_abort
);
  avc_state_e      state;       // Sequencer state
  logic [8:0]      word_cnt;    // Identify word counter
  logic [2:0]      wr_idx;      // Event register write step
  logic [7:0]      ev_code;     // Event notify command code
  logic            dev_sel;     // Selected drive
  logic            id_go;       // Identify request from software
  logic            id_done;     // Identify block captured
  logic            force_ev;    // Notify owed after drive reset/init
  logic [7:0]      out_lo;      // outgoing_saved_byte_lo
  logic [7:0]      out_hi;      // outgoing_saved_byte_hi
  logic [7:0]      ret_lo;      // returned_next_byte_lo held until pair is read
  logic [EV_W-1:0] snap;        // Flags carried by the command in flight
  logic [EV_W-1:0] pend;        // Pending event flags
  logic            done_ok;     // Event notify completed
  logic [7:0]      cfg_idx;     // Software read index into config store
  logic [7:0]      cfg_byte;    // Config store read data
  logic            ram_we;      // Store one identify word
  logic            xfer;        // Task file access finishes now
  logic            apb_acc;     // APB access phase, first cycle
  logic            ev_want;     // A notify is owed and enabled

  assign xfer    = tf_req && tf_ack;
  assign apb_acc = psel && penable && !pready;
  assign ev_want = (ev_code != EV_OFF) && ((pend != '0) || force_ev);
  assign ram_we  = (state == AVC_ID_DATA) && xfer && (word_cnt < KEEP_WORDS);

  // Pair accumulator for pending flags
  avc_evt_acc u_acc (
    .clk     (clk),
    .rst     (rst),
    .ev_in   (ev_in),
    .done_ok (done_ok),
    .snap    (snap),
    .pend    (pend)
  );

  // Store the kept half of the identify block
  avc_cfg_ram u_ram (
    .clk   (clk),
    .we    (ram_we),
    .waddr (word_cnt[6:0]),
    .wdata (tf_rdata),
    .raddr (cfg_idx),
    .rdata (cfg_byte)
  );

  // APB slave: one wait state, so read data and pready rise together
  always_ff @(posedge clk) begin
    if (rst) begin
      pready  <= 1'b0;
      prdata  <= '0;
      pslverr <= 1'b0;
      dev_sel <= 1'b0;
      cfg_idx <= '0;
      id_go   <= 1'b0;
    end else begin
      pready  <= apb_acc;
      pslverr <= 1'b0;
      // Start request is consumed when the sequencer leaves idle
      if (state == AVC_ID_DEV) begin
        id_go <= 1'b0;
      end
      if (apb_acc) begin
        unique case (paddr)
          REG_CTRL: begin
            if (pwrite) begin
              dev_sel <= pwdata[CTRL_DEV];
              if (pwdata[CTRL_START_ID]) begin
                id_go <= 1'b1;
              end
            end
            prdata <= {30'h0, dev_sel, id_go};
          end
          REG_STATUS: begin
            // Upper seven bits read zero; fields pack into the low 25 bits
            prdata <= {7'h0, pend, force_ev, id_done, ev_code, 1'b0, state};
          end
          REG_CFG_IDX: begin
            if (pwrite) begin
              cfg_idx <= pwdata[7:0];
            end
            prdata <= {24'h0, cfg_idx};
          end
          REG_CFG_DAT: begin
            prdata <= {24'h0, cfg_byte};
          end
          REG_STATE: begin
            prdata <= {16'h0, out_hi, out_lo};
          end
          default: begin
            // Unmapped: read zero, flag error
            prdata  <= '0;
            pslverr <= 1'b1;
          end
        endcase
      end
    end
  end

  // Notify owed after each drive reset or init; cleared only by success
  always_ff @(posedge clk) begin
    if (rst) begin
      force_ev <= 1'b0;
    end else if (drive_ready) begin
      force_ev <= 1'b1;
    end else if (done_ok) begin
      force_ev <= 1'b0;
    end
  end

  // Event code is taken from the identify word holding config byte 2
  always_ff @(posedge clk) begin
    if (rst) begin
      ev_code <= EV_OFF;
      id_done <= 1'b0;
    end else begin
      if (ram_we && word_cnt[6:0] == EVCODE_WORD) begin
        ev_code <= tf_rdata[7:0];
      end
      if (state == AVC_ID_DEV) begin
        id_done <= 1'b0;
      end else if (state == AVC_ID_END && xfer && !tf_rdata[ST_BSY]) begin
        id_done <= 1'b1;
      end
    end
  end

  // Saved state bytes; replaced only when both readbacks have landed
  always_ff @(posedge clk) begin
    if (rst) begin
      out_lo <= STATE_RST;
      out_hi <= STATE_RST;
      ret_lo <= STATE_RST;
    end else begin
      if (state == AVC_EV_RD_LO && xfer) begin
        ret_lo <= tf_rdata[7:0];
      end
      if (state == AVC_EV_RD_HI && xfer && !drive_abort) begin
        out_lo <= ret_lo;
        out_hi <= tf_rdata[7:0];
      end
    end
  end

  // Success pulse; ERR is never looked at
  always_ff @(posedge clk) begin
    if (rst) begin
      done_ok <= 1'b0;
    end else begin
      done_ok <= (state == AVC_EV_RD_HI) && xfer && !drive_abort;
    end
  end

  // Sequencer and task file access issue
  always_ff @(posedge clk) begin
    if (rst) begin
      state    <= AVC_IDLE;
      tf_req   <= 1'b0;
      tf_wr    <= 1'b0;
      tf_addr  <= TF_DATA;
      tf_wdata <= '0;
      word_cnt <= '0;
      wr_idx   <= '0;
      snap     <= '0;
    end else if (drive_abort) begin
      // Interrupted: pending flags stay, so the notify is retried
      state  <= AVC_IDLE;
      tf_req <= 1'b0;
    end else begin
      unique case (state)
        AVC_IDLE: begin
          // Identify from software first; it is rare and needs the code
          if (id_go) begin
            state    <= AVC_ID_DEV;
            tf_req   <= 1'b1;
            tf_wr    <= 1'b1;
            tf_addr  <= TF_DEVHD;
            tf_wdata <= {8'h0, 3'h0, dev_sel, DEVHD_LOW};
          end else if (ev_want && !done_ok) begin
            // done_ok lag: let the accumulator retire the last snapshot first
            state   <= AVC_EV_POLL0;
            snap    <= pend;
            tf_req  <= 1'b1;
            tf_wr   <= 1'b0;
            tf_addr <= TF_CMD;
          end
        end
        AVC_ID_DEV: begin
          if (xfer) begin
            state    <= AVC_ID_CMD;
            tf_addr  <= TF_CMD;
            tf_wdata <= {8'h0, CMD_IDENTIFY};
          end
        end
        AVC_ID_CMD: begin
          if (xfer) begin
            state <= AVC_ID_POLL;
            tf_wr <= 1'b0;
          end
        end
        AVC_ID_POLL: begin
          // Wait for the drive to offer data; an abort ends the command
          if (xfer && !tf_rdata[ST_BSY]) begin
            if (tf_rdata[ST_ERR]) begin
              state  <= AVC_IDLE;
              tf_req <= 1'b0;
            end else if (tf_rdata[ST_DRQ]) begin
              state    <= AVC_ID_DATA;
              tf_addr  <= TF_DATA;
              word_cnt <= '0;
            end
          end
        end
        AVC_ID_DATA: begin
          // All 256 words are read; only the first 128 reach the store
          if (xfer) begin
            word_cnt <= word_cnt + 9'h001;
            if (word_cnt == ID_WORDS - 9'h001) begin
              state   <= AVC_ID_END;
              tf_addr <= TF_CMD;
            end
          end
        end
        AVC_ID_END: begin
          if (xfer && !tf_rdata[ST_BSY]) begin
            state  <= AVC_IDLE;
            tf_req <= 1'b0;
          end
        end
        AVC_EV_POLL0: begin
          if (xfer && !tf_rdata[ST_BSY] && !tf_rdata[ST_DRQ]) begin
            state    <= AVC_EV_WR;
            wr_idx   <= '0;
            tf_wr    <= 1'b1;
            tf_addr  <= TF_FEAT;
            tf_wdata <= {8'h0, snap[EV_W-1:2]};
          end
        end
        AVC_EV_WR: begin
          // Register writes, command last, no data phase
          if (xfer) begin
            wr_idx <= wr_idx + 3'h1;
            unique case (wr_idx)
              3'h0: begin
                tf_addr  <= TF_SECCNT;
                tf_wdata <= {14'h0, snap[1:0]};
              end
              3'h1: begin
                tf_addr  <= TF_CYL_LO;
                tf_wdata <= {8'h0, out_lo};
              end
              3'h2: begin
                tf_addr  <= TF_CYL_HI;
                tf_wdata <= {8'h0, out_hi};
              end
              3'h3: begin
                tf_addr  <= TF_CMD;
                tf_wdata <= {8'h0, ev_code};
              end
              default: begin
                state <= AVC_EV_POLL1;
                tf_wr <= 1'b0;
              end
            endcase
          end
        end
        AVC_EV_POLL1: begin
          // DRQ never ends the wait: polling continues until it drops
          if (xfer && !tf_rdata[ST_BSY] && !tf_rdata[ST_DRQ]) begin
            state   <= AVC_EV_RD_LO;
            tf_addr <= TF_CYL_LO;
          end
        end
        AVC_EV_RD_LO: begin
          if (xfer) begin
            state   <= AVC_EV_RD_HI;
            tf_addr <= TF_CYL_HI;
          end
        end
        AVC_EV_RD_HI: begin
          if (xfer) begin
            state  <= AVC_IDLE;
            tf_req <= 1'b0;
          end
        end
        default: begin
          state  <= AVC_IDLE;
          tf_req <= 1'b0;
        end
      endcase
    end
  end

  // Checks on the command sequences
  sequence s_ev_cmd;
    tf_req && tf_wr && tf_addr == TF_CMD && state == AVC_EV_WR;
  endsequence

  id_cmd_code_a: assert property (@(posedge clk) disable iff (rst)
    state == AVC_ID_CMD |-> tf_wdata[7:0] == CMD_IDENTIFY && tf_wr)
    else $error("identify command code wrong");
  id_devhd_a: assert property (@(posedge clk) disable iff (rst)
    state == AVC_ID_DEV |-> tf_wdata[3:0] == DEVHD_LOW && tf_wdata[DEVHD_DEV] == dev_sel)
    else $error("identify device/head wrong");
  id_count_a: assert property (@(posedge clk) disable iff (rst)
    state == AVC_ID_DATA && xfer && !drive_abort
      |=> (state == AVC_ID_END) == ($past(word_cnt) == ID_WORDS - 9'h001))
    else $error("identify data phase length wrong");
  ev_off_a: assert property (@(posedge clk) disable iff (rst)
    ev_code == EV_OFF |-> ##1 state != AVC_EV_POLL0 || $past(state) == AVC_EV_POLL0)
    else $error("notify started while disabled");
  ev_cmd_a: assert property (@(posedge clk) disable iff (rst)
    s_ev_cmd |-> tf_wdata[7:0] == ev_code && wr_idx == 3'h4)
    else $error("notify command not last or wrong code");
  ev_regs_a: assert property (@(posedge clk) disable iff (rst)
    state == AVC_EV_WR && tf_addr == TF_CYL_LO |-> tf_wdata[7:0] == out_lo)
    else $error("saved state byte not sent");
  ev_poll_a: assert property (@(posedge clk) disable iff (rst || drive_abort)
    state == AVC_EV_POLL1 && xfer && tf_rdata[ST_DRQ] |=> state == AVC_EV_POLL1)
    else $error("notify left polling with DRQ set");
  ev_save_a: assert property (@(posedge clk) disable iff (rst)
    state == AVC_EV_RD_HI && xfer && !drive_abort |=> out_hi == $past(tf_rdata[7:0]) ##0 done_ok)
    else $error("next-state bytes not kept");
  ev_retry_a: assert property (@(posedge clk) disable iff (rst)
    drive_abort && state != AVC_IDLE && state >= AVC_EV_POLL0
      |=> pend == ($past(pend) | $past(ev_in)))
    else $error("pending flags lost on abort");
  ev_force_a: assert property (@(posedge clk) disable iff (rst)
    drive_ready |=> force_ev)
    else $error("drive reset did not owe a notify");
endmodule
`default_nettype wire

// *** verif/avc_drive_model.sv ***
// Behavioural drive behind the task file port
`timescale 1ns/100ps
`default_nettype none
module avc_drive_model
  import avc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        tf_req,
  input  wire logic        tf_wr,
  input  wire logic [2:0]  tf_addr,
  input  wire logic [15:0] tf_wdata,
  output logic             tf_ack,
  output logic      [15:0] tf_rdata,
  input  wire logic [3:0]  dly,
  input  wire logic [3:0]  nbusy,
  input  wire logic [3:0]  ndrq,
  input  wire logic        err_end,
  input  wire logic        unsup,
  input  wire logic [7:0]  code
);
  logic [55:0] log_q[$];  // Per command: {cmd,feat,sc,lo,hi,nlo,nhi}
  logic [7:0]  feat, sc, lo, hi, nlo, nhi, devhd, cyc;
  int          cnt, busy, drq, nword, nviol;
  logic        id_st, id_dat;  // Identify status owed, data phase open

  // Identify byte pattern; byte 2 holds the event code
  function automatic logic [7:0] idb(input int b);
    return (b == 2) ? code : (8'(b) ^ 8'h5a);
  endfunction

  // One access per request after dly cycles; idle bus churns so stale data never looks valid
  // Plain always: the bench pops the command log from its own process
  always @(posedge clk) begin
    cyc <= cyc + 8'h01;
    tf_ack <= 1'b0;
    tf_rdata <= {cyc, ~cyc};
    if (rst) begin
      cyc <= 8'h00;
      cnt <= 0;
      busy <= 0;
      drq <= 0;
      nviol <= 0;
      id_st <= 1'b0;
      id_dat <= 1'b0;
    end else if (tf_req && !tf_ack && cnt < int'(dly)) begin
      cnt <= cnt + 1;
    end else if (tf_req && !tf_ack) begin
      cnt <= 0;
      tf_ack <= 1'b1;
      if (tf_wr) begin
        if (busy > 0 || drq > 0) nviol <= nviol + 1;
        case (tf_addr)
          TF_FEAT:   feat <= tf_wdata[7:0];
          TF_SECCNT: sc <= tf_wdata[7:0];
          TF_CYL_LO: lo <= tf_wdata[7:0];
          TF_CYL_HI: hi <= tf_wdata[7:0];
          TF_DEVHD:  devhd <= tf_wdata[7:0];
          TF_CMD: begin
            // New command accepted even if last readback never came
            log_q.push_back({tf_wdata[7:0], feat, sc, lo, hi, cyc, ~cyc});
            nlo <= cyc;
            nhi <= ~cyc;
            busy <= int'(nbusy);
            drq <= (tf_wdata[7:0] == CMD_IDENTIFY) ? 0 : int'(ndrq);
            id_st <= (tf_wdata[7:0] == CMD_IDENTIFY);
            id_dat <= 1'b0;
            nword <= 0;
          end
          default: nviol <= nviol + 1;
        endcase
      end else begin
        case (tf_addr)
          TF_CMD: begin
            if (busy > 0) begin
              busy <= busy - 1;
              tf_rdata <= 16'h0080;
            end else if (id_st) begin
              id_st <= 1'b0;
              id_dat <= !unsup;
              tf_rdata <= unsup ? 16'h0041 : 16'h0048;
            end else if (drq > 0) begin
              drq <= drq - 1;
              tf_rdata <= 16'h0048;
            end else begin
              tf_rdata <= {15'h0020, err_end};
            end
          end
          TF_DATA: begin
            if (id_dat && nword < 256) begin
              tf_rdata <= {idb(2 * nword + 1), idb(2 * nword)};
              nword <= nword + 1;
            end else nviol <= nviol + 1;
          end
          TF_CYL_LO: begin
            if (busy > 0 || drq > 0) nviol <= nviol + 1;
            tf_rdata <= {8'h00, nlo};
          end
          TF_CYL_HI: tf_rdata <= {8'h00, nhi};
          default: nviol <= nviol + 1;
        endcase
      end
    end else begin
      cnt <= 0;
    end
  end
endmodule
`default_nettype wire

// *** verif/ata_vendor_command_issuer_tb.sv ***
// Self-checking bench for the vendor command issuer
`timescale 1ns/100ps
`default_nettype none
module ata_vendor_command_issuer_tb;
  import avc_pkg::*;
  logic            clk, rst, psel, penable, pwrite, pready, pslverr, perr;
  logic [7:0]      paddr, code, exp_lo, exp_hi, idx;
  logic [31:0]     pwdata, prdata, rd, seed;
  logic            tf_req, tf_wr, tf_ack, drive_ready, drive_abort, err_end, unsup;
  logic [2:0]      tf_addr;
  logic [15:0]     tf_wdata, tf_rdata;
  logic [EV_W-1:0] ev_in, ev;
  logic [3:0]      dly, nbusy, ndrq;
  logic [55:0]     ent;
  int              miscompares, n_compared;

  avc_issuer uut (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .tf_req(tf_req), .tf_wr(tf_wr), .tf_addr(tf_addr), .tf_wdata(tf_wdata),
    .tf_ack(tf_ack), .tf_rdata(tf_rdata), .ev_in(ev_in), .drive_ready(drive_ready),
    .drive_abort(drive_abort));
  avc_drive_model drv (.clk(clk), .rst(rst), .tf_req(tf_req), .tf_wr(tf_wr),
    .tf_addr(tf_addr), .tf_wdata(tf_wdata), .tf_ack(tf_ack), .tf_rdata(tf_rdata),
    .dly(dly), .nbusy(nbusy), .ndrq(ndrq), .err_end(err_end), .unsup(unsup), .code(code));

  // Free-running 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Fixed-seed xorshift source
  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  task automatic finish_test();
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // One APB transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 100);
    if (n >= 100) begin
      miscompares++;
      finish_test();
    end
    rd = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Poll status until idle with nothing owed or pending
  task automatic wait_idle();
    int n;
    n = 0;
    do begin
      apb(1'b0, REG_STATUS, 32'h0);
      n++;
    end while ((rd[3:0] !== AVC_IDLE || rd[14] !== 1'b0 || rd[24:15] !== '0) && n < 300);
    if (n >= 300) begin
      miscompares++;
      finish_test();
    end
  endtask

  // Wait until the drive has taken a command write
  task automatic wait_log();
    int n;
    for (n = 0; n < 300 && drv.log_q.size() == 0; n++) @(posedge clk);
    if (n >= 300) begin
      miscompares++;
      finish_test();
    end
  endtask

  task automatic pulse(input logic [EV_W-1:0] e, input logic rdy, input logic ab);
    @(posedge clk);
    ev_in <= e;
    drive_ready <= rdy;
    drive_abort <= ab;
    @(posedge clk);
    ev_in <= '0;
    drive_ready <= 1'b0;
    drive_abort <= 1'b0;
  endtask

  // Compare one logged notify with the expected flags and carried state
  task automatic chk_cmd(input logic [7:0] f, input logic [1:0] s, input logic ok);
    if (drv.log_q.size() == 0) begin
      chk("cmd_count", 32'h0, 32'h1);
      return;
    end
    ent = drv.log_q.pop_front();
    chk("cmd_code", ent[55:48], code);
    chk("features", ent[47:40], f);
    chk("sec_count", ent[39:32], {6'h00, s});
    chk("cyl_lo", ent[31:24], exp_lo);
    chk("cyl_hi", ent[23:16], exp_hi);
    if (ok) begin
      exp_lo = ent[15:8];
      exp_hi = ent[7:0];
    end
  endtask

  initial begin
    {rst, psel, penable, pwrite, paddr, pwdata, ev_in, drive_ready, drive_abort} = '0;
    rst = 1'b1;
    {dly, nbusy, ndrq, err_end, unsup, code} = {4'h1, 4'h2, 4'h0, 1'b0, 1'b1, 8'h00};
    {exp_lo, exp_hi, seed, miscompares, n_compared} = {16'h0, 32'd20, 64'd0};
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, REG_STATE, 32'h0);
    chk("state_rst", rd, 32'h0);
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped", {31'h0, perr}, 32'h1);
    // Drive lacking the command aborts the identify
    apb(1'b1, REG_CTRL, 32'h3);
    wait_idle();
    chk("id_abort", {31'h0, rd[13]}, 32'h0);
    ent = drv.log_q.pop_front();
    chk("id_cmd", ent[55:48], CMD_IDENTIFY);
    chk("devhd1", {27'h0, drv.devhd[4:0]}, 32'h11);
    seed = xs(seed);
    code <= seed[7:0] | 8'h01;
    unsup <= 1'b0;
    apb(1'b1, REG_CTRL, 32'h1);
    wait_idle();
    chk("id_done", {31'h0, rd[13]}, 32'h1);
    chk("ev_code", rd[12:5], code);
    chk("id_words", drv.nword, 32'd256);
    chk("devhd0", {27'h0, drv.devhd[4:0]}, 32'h01);
    ent = drv.log_q.pop_front();
    for (int i = 0; i < 8; i++) begin
      seed = xs(seed);
      idx = (i == 0) ? 8'h02 : seed[7:0];
      apb(1'b1, REG_CFG_IDX, {24'h0, idx});
      apb(1'b0, REG_CFG_DAT, 32'h0);
      chk("cfg_byte", rd[7:0], drv.idb(int'(idx)));
    end
    // Drive ready brings the first notify
    nbusy <= 4'h3;
    pulse('0, 1'b1, 1'b0);
    wait_idle();
    chk_cmd(8'h00, 2'b00, 1'b1);
    // Each event alone, random drive pacing, DRQ and ERR cases
    for (int b = 0; b < EV_W; b++) begin
      seed = xs(seed);
      dly <= {2'b00, seed[1:0]};
      nbusy <= {1'b0, seed[4:2]};
      ndrq <= (b == 3) ? 4'h3 : 4'h0;
      err_end <= (b == 5);
      ev = EV_W'(1) << b;
      pulse(ev, 1'b0, 1'b0);
      wait_idle();
      chk_cmd(ev[9:2], ev[1:0], 1'b1);
      chk("one_cmd", drv.log_q.size(), 32'h0);
      apb(1'b0, REG_STATE, 32'h0);
      chk("state", rd[15:0], {exp_hi, exp_lo});
    end
    // Paired events stack up behind a slow command
    {dly, nbusy} <= {4'h2, 4'h8};
    pulse(10'h200, 1'b0, 1'b0);
    wait_log();
    pulse(10'h080, 1'b0, 1'b0);
    pulse(10'h040, 1'b0, 1'b0);
    wait_idle();
    chk_cmd(8'h80, 2'b00, 1'b1);
    chk_cmd(8'h30, 2'b00, 1'b1);
    chk_cmd(8'h10, 2'b00, 1'b1);
    // Abort mid-command, newer event merged into the retry
    pulse(10'h020, 1'b0, 1'b0);
    wait_log();
    pulse(10'h004, 1'b0, 1'b1);
    wait_idle();
    chk_cmd(8'h08, 2'b00, 1'b0);
    chk_cmd(8'h09, 2'b00, 1'b1);
    chk("drive_viol", drv.nviol, 32'h0);
    // Reset again: state bytes and event code cleared
    rst <= 1'b1;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, REG_STATE, 32'h0);
    chk("state_rst2", rd, 32'h0);
    pulse('0, 1'b1, 1'b0);
    repeat (50) @(posedge clk);
    chk("code_off", drv.log_q.size(), 32'h0);
    finish_test();
  end
endmodule
`default_nettype wire
